// file: logic/gls_blink.sv
`timescale 1ns/1ps
`default_nettype none
module gls_blink (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic activity,
  input wire logic link_valid,
  output logic restart,
  output logic lamp_off
);
  gls_pkg::gls_blink_t st_r;
  gls_pkg::gls_blink_t st_nxt;
  logic [gls_pkg::BLINK_CNT_W-1:0] cnt_r;
  logic [gls_pkg::BLINK_CNT_W-1:0] cnt_nxt;
  logic pend_r;
  logic pend_nxt;
  logic last;

  assign last = tick && (cnt_r == gls_pkg::BLINK_CNT_W'(gls_pkg::BLINK_TICKS - 1));

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    pend_nxt = (pend_r || activity) && link_valid;
    restart = 1'b0;
    case (st_r)
      gls_pkg::GLS_IDLE: begin
        if (link_valid && (activity || pend_r)) begin // RQ6
          st_nxt = gls_pkg::GLS_OFF;
          cnt_nxt = '0;
          pend_nxt = 1'b0;
          restart = 1'b1;
        end
      end
      gls_pkg::GLS_OFF: begin
        if (last) begin // RQ6
          st_nxt = gls_pkg::GLS_HOLD;
          cnt_nxt = '0;
          restart = 1'b1;
        end else if (tick) begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      gls_pkg::GLS_HOLD: begin
        if (last) begin // RQ7
          st_nxt = gls_pkg::GLS_IDLE;
          cnt_nxt = '0;
        end else if (tick) begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: begin
        st_nxt = gls_pkg::GLS_IDLE;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= gls_pkg::GLS_IDLE;
      cnt_r <= '0;
      pend_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      pend_r <= pend_nxt;
    end
  end

  assign lamp_off = (st_r == gls_pkg::GLS_OFF);

  a_off_full_phase: assert property (@(posedge clk) disable iff (!nrst) // RQ6
    $fell(lamp_off) |-> $past(cnt_r) ==
      gls_pkg::BLINK_CNT_W'(gls_pkg::BLINK_TICKS - 1) && $past(tick))
    else $error("off pulse ended early");
  a_hold_before_off: assert property (@(posedge clk) disable iff (!nrst) // RQ7
    $rose(lamp_off) |-> $past(st_r) == gls_pkg::GLS_IDLE)
    else $error("off pulse started without low hold");
endmodule // gls_blink
`default_nettype wire

// file: logic/gls_pkg.sv
`default_nettype none
package gls_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLINK_PHASE_MS = 80;
  localparam int BLINK_TICKS = BLINK_PHASE_MS * TICK_PERIOD_NS / 1000000;
  localparam int BLINK_CNT_W = 7;
  localparam int TICK_CNT_W = 32;

  // Pins and bus
  localparam int NPINS = 3;
  localparam int ADR_W = 4;
  localparam logic [ADR_W-1:0] ADDR_CFG = 4'h0;
  localparam logic [ADR_W-1:0] ADDR_DATA = 4'h4;
  localparam logic [ADR_W-1:0] ADDR_STAT = 4'h8;

  // Configuration fields, one bit per pin
  localparam int CFG_OUT_LSB = 0;
  localparam int CFG_OD_LSB = 8;
  localparam int CFG_LAMP_LSB = 16;
  // Data fields
  localparam int DATA_OUT_LSB = 0;
  localparam int DATA_IN_LSB = 8;
  // Status bits
  localparam int STAT_LINK = 0;
  localparam int STAT_SPD10 = 1;
  localparam int STAT_FDX = 2;
  localparam int STAT_ANEG = 3;
  localparam int STAT_BLINK = 4;

  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  // Pin index of each lamp
  localparam int PIN_SPEED = 0;
  localparam int PIN_LINKACT = 1;
  localparam int PIN_DUPLEX = 2;

  typedef enum logic [1:0] {
    GLS_IDLE,
    GLS_OFF,
    GLS_HOLD
  } gls_blink_t;
endpackage
`default_nettype wire

// file: logic/gls_tick.sv
`timescale 1ns/1ps
`default_nettype none
module gls_tick #(
  parameter int TICK = gls_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clr,
  output logic tick
);
  logic [gls_pkg::TICK_CNT_W-1:0] cnt_r;
  logic [gls_pkg::TICK_CNT_W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    cnt_nxt = cnt_r + 1'b1;
    tick_nxt = 1'b0;
    if (clr) begin
      cnt_nxt = '0;
    end else if (cnt_r == gls_pkg::TICK_CNT_W'(TICK - 1)) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule // gls_tick
`default_nettype wire

// file: logic/gls_top.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// RQ1 - Each of three pins is set to push-pull, open-drain or input by software.
// RQ2 - Pins may carry status lamps instead; lamp pins are always open-drain.
// RQ3 - Speed lamp low at 100Mbs, during auto-negotiation and with no cable.
// RQ4 - Speed lamp high only while the link runs at 10Mbs.
// RQ5 - Link/activity lamp low with valid link and no blink in progress.
// RQ6 - Activity pulses link/activity lamp high for 80 ms.
// RQ7 - After a pulse lamp stays low 80 ms minimum, then may pulse again.
// RQ8 - Duplex lamp low while link runs full duplex.
// RQ9 - A lamp whose low condition fails is released high.
module gls_top #(
  parameter int TICK_CYCLES = gls_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [gls_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic link_valid,
  input wire logic link_speed_10,
  input wire logic link_full_duplex,
  input wire logic autoneg_busy,
  input wire logic tx_activity,
  input wire logic rx_activity,
  input wire logic [gls_pkg::NPINS-1:0] indicator_pins_in,
  output logic [gls_pkg::NPINS-1:0] indicator_pins_out,
  output logic [gls_pkg::NPINS-1:0] indicator_pins_oe_n,
  output logic speed_lamp_n,
  output logic link_activity_lamp_n,
  output logic duplex_lamp_n
);

  //////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Register slave
  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic [31:0] data_r;
  logic [31:0] data_nxt;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [gls_pkg::NPINS-1:0] pin_in_r;
  logic [gls_pkg::NPINS-1:0] pin_in_nxt;
  logic [31:0] stat_word;
  logic blink_off;
  logic wr_now;

  assign wr_now = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[gls_pkg::STAT_LINK] = link_valid;
    stat_word[gls_pkg::STAT_SPD10] = link_speed_10;
    stat_word[gls_pkg::STAT_FDX] = link_full_duplex;
    stat_word[gls_pkg::STAT_ANEG] = autoneg_busy;
    stat_word[gls_pkg::STAT_BLINK] = blink_off;
  end

  always_comb begin
    cfg_nxt = cfg_r;
    data_nxt = data_r;
    ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
    rdat_nxt = rdat_r;
    pin_in_nxt = indicator_pins_in;
    if (wb_cyc_i && wb_stb_i && !ack_r) begin
      case (wb_adr_i)
        gls_pkg::ADDR_CFG: rdat_nxt = cfg_r;
        gls_pkg::ADDR_DATA: begin
          rdat_nxt = data_r;
          rdat_nxt[gls_pkg::DATA_IN_LSB +: gls_pkg::NPINS] = pin_in_r;
        end
        gls_pkg::ADDR_STAT: rdat_nxt = stat_word;
        default: rdat_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_now) begin
      case (wb_adr_i)
        gls_pkg::ADDR_CFG: cfg_nxt = merge(cfg_r, wb_dat_i, wb_sel_i); // RQ1
        gls_pkg::ADDR_DATA: data_nxt = merge(data_r, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= gls_pkg::CFG_RST;
      data_r <= gls_pkg::DATA_RST;
      rdat_r <= 32'h0000_0000;
      ack_r <= 1'b0;
      pin_in_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      data_r <= data_nxt;
      rdat_r <= rdat_nxt;
      ack_r <= ack_nxt;
      pin_in_r <= pin_in_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  //////////////////////////////////////////////////////////////////////////////
  // Activity blink timing
  logic tick;
  logic restart;

  gls_tick #(
    .TICK(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .nrst(nrst),
    .clr(restart),
    .tick(tick)
  );

  gls_blink u_blink (
    .clk(clk),
    .nrst(nrst),
    .tick(tick),
    .activity(tx_activity || rx_activity),
    .link_valid(link_valid),
    .restart(restart),
    .lamp_off(blink_off)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Lamp levels
  logic [gls_pkg::NPINS-1:0] lamp_n_nxt;
  logic [gls_pkg::NPINS-1:0] lamp_n_r;

  always_comb begin
    // High only at 10Mbs with link up and negotiation done
    lamp_n_nxt[gls_pkg::PIN_SPEED] =
      link_valid && link_speed_10 && !autoneg_busy; // RQ3 RQ4
    // Off without link or during an off pulse
    lamp_n_nxt[gls_pkg::PIN_LINKACT] = !link_valid || blink_off; // RQ5 RQ9
    lamp_n_nxt[gls_pkg::PIN_DUPLEX] = !(link_valid && link_full_duplex); // RQ8 RQ9
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lamp_n_r <= '1;
    end else begin
      lamp_n_r <= lamp_n_nxt;
    end
  end

  assign speed_lamp_n = lamp_n_r[gls_pkg::PIN_SPEED];
  assign link_activity_lamp_n = lamp_n_r[gls_pkg::PIN_LINKACT];
  assign duplex_lamp_n = lamp_n_r[gls_pkg::PIN_DUPLEX];

  //////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  logic [gls_pkg::NPINS-1:0] pout_nxt;
  logic [gls_pkg::NPINS-1:0] poe_n_nxt;
  logic [gls_pkg::NPINS-1:0] pout_r;
  logic [gls_pkg::NPINS-1:0] poe_n_r;

  for (genvar i = 0; i < gls_pkg::NPINS; i++) begin : g_pin
    logic lamp_sel;
    logic is_out;
    logic is_od;
    logic val;
    assign lamp_sel = cfg_r[gls_pkg::CFG_LAMP_LSB + i];
    assign is_out = cfg_r[gls_pkg::CFG_OUT_LSB + i];
    assign is_od = cfg_r[gls_pkg::CFG_OD_LSB + i];
    assign val = data_r[gls_pkg::DATA_OUT_LSB + i];
    always_comb begin
      if (lamp_sel) begin
        // Lamp pins only ever pull low
        pout_nxt[i] = 1'b0; // RQ2
        poe_n_nxt[i] = lamp_n_nxt[i]; // RQ2
      end else if (!is_out) begin
        pout_nxt[i] = 1'b0;
        poe_n_nxt[i] = 1'b1; // RQ1
      end else if (is_od) begin
        pout_nxt[i] = 1'b0;
        poe_n_nxt[i] = val; // RQ1
      end else begin
        pout_nxt[i] = val;
        poe_n_nxt[i] = 1'b0; // RQ1
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pout_r <= '0;
      poe_n_r <= '1;
    end else begin
      pout_r <= pout_nxt;
      poe_n_r <= poe_n_nxt;
    end
  end

  assign indicator_pins_out = pout_r;
  assign indicator_pins_oe_n = poe_n_r;

  //////////////////////////////////////////////////////////////////////////////
  // Run length of the current blink level, for the checks below
  logic [31:0] run_cnt_r;
  logic [31:0] run_cnt_nxt;
  logic blink_d_r;
  logic blink_d_nxt;

  always_comb begin
    blink_d_nxt = blink_off;
    run_cnt_nxt = run_cnt_r;
    if (blink_off != blink_d_r) begin
      run_cnt_nxt = 32'h0000_0001;
    end else if (run_cnt_r != 32'hffff_ffff) begin
      run_cnt_nxt = run_cnt_r + 32'h0000_0001;
    end
  end

  // Starts saturated so the first pulse after reset needs no gap
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_cnt_r <= 32'hffff_ffff;
      blink_d_r <= 1'b0;
    end else begin
      run_cnt_r <= run_cnt_nxt;
      blink_d_r <= blink_d_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_speed_low_cases: assert property (@(posedge clk) disable iff (!nrst) // RQ3
    (!link_valid || !link_speed_10 || autoneg_busy) |=> !speed_lamp_n)
    else $error("speed lamp not low");
  // Reset leaves every lamp released for one cycle
  a_speed_high_10m: assert property (@(posedge clk) disable iff (!nrst) // RQ4
    speed_lamp_n |->
      $past(link_valid && link_speed_10 && !autoneg_busy) || $past(!nrst))
    else $error("speed lamp high outside 10Mbs");
  a_link_lamp_on: assert property (@(posedge clk) disable iff (!nrst) // RQ5
    (link_valid && !blink_off) |=> !link_activity_lamp_n)
    else $error("link lamp not on");
  a_blink_lamp_off: assert property (@(posedge clk) disable iff (!nrst) // RQ6
    $rose(blink_off) |=> link_activity_lamp_n)
    else $error("activity did not turn lamp off");
  a_blink_low_gap: assert property (@(posedge clk) disable iff (!nrst) // RQ7
    $fell(blink_off) |-> !blink_off [*8])
    else $error("low gap after pulse too short");
  a_duplex_lamp: assert property (@(posedge clk) disable iff (!nrst) // RQ8
    (link_valid && link_full_duplex) |=> !duplex_lamp_n)
    else $error("duplex lamp not on");
  a_lamp_release: assert property (@(posedge clk) disable iff (!nrst) // RQ9
    !link_valid |=> link_activity_lamp_n && duplex_lamp_n)
    else $error("lamp not released without link");
  a_lamp_od_only: assert property (@(posedge clk) disable iff (!nrst) // RQ2
    $past(cfg_r[gls_pkg::CFG_LAMP_LSB]) |->
      !indicator_pins_out[gls_pkg::PIN_SPEED] &&
      indicator_pins_oe_n[gls_pkg::PIN_SPEED] == speed_lamp_n)
    else $error("lamp pin not open-drain");
  a_pin_input_mode: assert property (@(posedge clk) disable iff (!nrst) // RQ1
    $past(cfg_r[gls_pkg::CFG_LAMP_LSB +: gls_pkg::NPINS] == '0 &&
          cfg_r[gls_pkg::CFG_OUT_LSB +: gls_pkg::NPINS] == '0) |->
      indicator_pins_oe_n == '1)
    else $error("input pin is driven");
  a_pin_push_pull: assert property (@(posedge clk) disable iff (!nrst) // RQ1
    $past(cfg_r[gls_pkg::CFG_LAMP_LSB +: gls_pkg::NPINS] == '0 &&
          cfg_r[gls_pkg::CFG_OUT_LSB +: gls_pkg::NPINS] == '1 &&
          cfg_r[gls_pkg::CFG_OD_LSB +: gls_pkg::NPINS] == '0) |->
      indicator_pins_oe_n == '0 &&
      indicator_pins_out ==
        $past(data_r[gls_pkg::DATA_OUT_LSB +: gls_pkg::NPINS]))
    else $error("push-pull pin not driven");
  a_off_phase_len: assert property (@(posedge clk) disable iff (!nrst) // RQ6
    $fell(blink_off) |->
      run_cnt_r >= 32'(gls_pkg::BLINK_TICKS * TICK_CYCLES) &&
      run_cnt_r <= 32'(gls_pkg::BLINK_TICKS * TICK_CYCLES + 1))
    else $error("off pulse length wrong");
  a_hold_phase_len: assert property (@(posedge clk) disable iff (!nrst) // RQ7
    $rose(blink_off) |->
      run_cnt_r >= 32'(gls_pkg::BLINK_TICKS * TICK_CYCLES))
    else $error("low gap before pulse too short");
  a_duplex_half: assert property (@(posedge clk) disable iff (!nrst) // RQ9
    (link_valid && !link_full_duplex) |=> duplex_lamp_n)
    else $error("duplex lamp on in half duplex");
  a_ack_one_cycle: assert property (@(posedge clk) disable iff (!nrst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule // gls_top
`default_nettype wire

// file: tb/gls_board.sv
`timescale 1ns/1ps
`default_nettype none
module gls_board (
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe_n,
  input wire logic [2:0] ext_en,
  input wire logic [2:0] ext_val,
  output logic [2:0] pin_lvl
);
  ////////////////////////////////////////////////////////////////////////////
  // Lamps and pull-ups to the supply; board may drive released pins
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!pin_oe_n[i]) begin
        pin_lvl[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_lvl[i] = ext_val[i];
      end else begin
        pin_lvl[i] = 1'b1;
      end
    end
  end
endmodule // gls_board
`default_nettype wire

// file: tb/gls_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gls_top_tb;
  localparam int TK = 4;
  localparam int P = gls_pkg::BLINK_TICKS * TK;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [gls_pkg::ADR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic link = 1'b0;
  logic spd10 = 1'b0;
  logic fdx = 1'b0;
  logic aneg = 1'b0;
  logic txa = 1'b0;
  logic rxa = 1'b0;
  logic [2:0] ext_en = 3'h0;
  logic [2:0] ext_val = 3'h0;
  logic [2:0] lvl, pout, poe_n;
  logic spd_n, la_n, dup_n;
  int n_mismatch = 0;
  int checks = 0;
  int n;
  logic [2:0] exp_lamp;

  always #2.5 clk = ~clk;

  gls_top #(.TICK_CYCLES(TK)) DUT (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .link_valid(link),
    .link_speed_10(spd10), .link_full_duplex(fdx),
    .autoneg_busy(aneg), .tx_activity(txa), .rx_activity(rxa),
    .indicator_pins_in(lvl), .indicator_pins_out(pout),
    .indicator_pins_oe_n(poe_n), .speed_lamp_n(spd_n),
    .link_activity_lamp_n(la_n), .duplex_lamp_n(dup_n)
  );

  gls_board board (
    .pin_out(pout), .pin_oe_n(poe_n), .ext_en(ext_en),
    .ext_val(ext_val), .pin_lvl(lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cy(input int c);
    repeat (c) @(posedge clk);
  endtask

  // One classic cycle; held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hf, q);
    chk(q, e);
  endtask

  // Cycles the link/activity lamp stays at one level
  task automatic span(input logic v, input int lim, output int c);
    c = 0;
    while (la_n === v && c < lim) begin
      @(posedge clk);
      c++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cy(6);
    nrst <= 1'b1;
    @(posedge clk);
    chk({poe_n, pout}, 6'h38);
    rd(gls_pkg::ADDR_CFG, 32'h0);
    rd(gls_pkg::ADDR_DATA, 32'h0000_0700);
    rd(4'hc, 32'h0);
    // Push-pull outputs
    wr(gls_pkg::ADDR_CFG, 32'h0000_0007, 4'hf);
    wr(gls_pkg::ADDR_DATA, 32'h0000_0005, 4'hf);
    cy(2);
    chk({poe_n, pout}, 6'h05);
    rd(gls_pkg::ADDR_DATA, 32'h0000_0505);
    // Open-drain outputs; released pins pulled high
    wr(gls_pkg::ADDR_CFG, 32'h0000_0707, 4'hf);
    wr(gls_pkg::ADDR_DATA, 32'h0000_0006, 4'hf);
    wr(gls_pkg::ADDR_DATA, 32'h0000_00ff, 4'h2);
    cy(2);
    chk({poe_n, pout}, 6'h30);
    rd(gls_pkg::ADDR_DATA, 32'h0000_0606);
    // Inputs driven by the board
    ext_en <= 3'h7;
    ext_val <= 3'h3;
    wr(gls_pkg::ADDR_CFG, 32'h0, 4'hf);
    cy(2);
    chk(poe_n, 3'h7);
    rd(gls_pkg::ADDR_DATA, 32'h0000_0306);
    ext_en <= 3'h0;
    // Lamp mode on all pins, every link state
    wr(gls_pkg::ADDR_CFG, 32'h0007_0707, 4'hf);
    for (int i = 0; i < 16; i++) begin
      {link, spd10, fdx, aneg} <= i[3:0];
      exp_lamp = {!(i[3] && i[1]), !i[3], i[3] && i[2] && !i[0]};
      cy(3);
      chk(spd_n, exp_lamp[0]);
      chk(la_n, exp_lamp[1]);
      chk(dup_n, exp_lamp[2]);
      chk({poe_n, pout}, {exp_lamp, 3'h0});
      chk(lvl, exp_lamp);
    end
    rd(gls_pkg::ADDR_STAT, 32'h0000_000f);
    // Activity blink
    {link, spd10, fdx, aneg} <= 4'h8;
    cy(3);
    txa <= 1'b1;
    @(posedge clk);
    txa <= 1'b0;
    span(1'b0, 5, n);
    chk(n <= 3, 1'b1);
    span(1'b1, 2 * P, n);
    chk(n >= P && n <= P + 3, 1'b1);
    rxa <= 1'b1;
    span(1'b0, 2 * P, n);
    chk(n >= P && n <= P + 3, 1'b1);
    rxa <= 1'b0;
    span(1'b1, 2 * P, n);
    chk(n >= P && n <= P + 3, 1'b1);
    // Activity seen during that pulse gives one more after the gap
    span(1'b0, 2 * P, n);
    chk(n >= P && n <= P + 3, 1'b1);
    span(1'b1, 2 * P, n);
    chk(n >= P && n <= P + 3, 1'b1);
    span(1'b0, 3 * P, n);
    chk(n, 3 * P);
    give_verdict();
  end

  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
endmodule // gls_top_tb
`default_nettype wire
